// *** inc/tmt_pkg.sv ***
// Package for the triple mode timer: register layout, mode codes, constants
package tmt_pkg;

  // Word widths
  localparam int CNT_W = 16;
  localparam int REG_W = 8;

  // Register offsets on the plain port
  localparam logic [2:0] OFF_CTRL  = 3'h0;  // second_timer_control_reg
  localparam logic [2:0] OFF_CNT_L = 3'h1;
  localparam logic [2:0] OFF_CNT_H = 3'h2;
  localparam logic [2:0] OFF_RA_L  = 3'h3;
  localparam logic [2:0] OFF_RA_H  = 3'h4;
  localparam logic [2:0] OFF_RB_L  = 3'h5;
  localparam logic [2:0] OFF_RB_H  = 3'h6;
  localparam logic [2:0] OFF_TICK  = 3'h7;  // Instruction-cycle divider setting

  // Control register bit positions
  localparam int B_M3   = 7;
  localparam int B_M2   = 6;
  localparam int B_M1   = 5;
  localparam int B_RUN  = 4;
  localparam int B_PNDA = 3;
  localparam int B_ENA  = 2;
  localparam int B_PNDB = 1;
  localparam int B_ENB  = 0;

  // Reset values
  localparam logic [REG_W-1:0] CTRL_RST = 8'h00;
  localparam logic [REG_W-1:0] TICK_RST = 8'h7C;  // 125 cycles per tick = 1 us
  localparam logic [REG_W-1:0] ZERO8    = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // Operating modes
  typedef enum logic [1:0] {
    TMT_PWM,
    TMT_EVENT,
    TMT_CAPTURE
  } tmt_mode_type;

  // Control register fields
  typedef struct packed {
    logic m3;
    logic m2;
    logic m1;
    logic run;
    logic pnda;
    logic ena;
    logic pndb;
    logic enb;
  } tmt_ctrl_type;

  // Register port request
  typedef struct packed {
    logic [2:0]       addr;
    logic [REG_W-1:0] wdata;
    logic             wr;
    logic             rd;
  } tmt_bus_type;

endpackage : tmt_pkg

// *** core/tmt_timer.sv ***
// Triple mode timer: PWM, external event counter and input capture
//
// Operation
// RQ1 - PWM mode counts down each instruction cycle and reloads alternately on underflow.
// RQ2 - First PWM underflow reloads from register A, then B, A, B onward.
// RQ3 - Code 1,0,1 toggles pin A each underflow; code 1,0,0 leaves it alone.
// RQ4 - PWM sets pending A on reloads from A, pending B on reloads from B.
// RQ5 - Software clears pending flags; hardware keeps them set until then.
// RQ6 - Interrupt request raised when a pending flag and its enable are both one.
// RQ7 - Run bit starts counting at one, halts at zero in PWM and event modes.
// RQ8 - Mode bits select PWM (1,0,x), event (0,0,x) or capture otherwise.
// RQ9 - Event mode decrements on selected pin A edge, not instruction clock.
// RQ10 - Event mode underflow sets pending A, interrupt gated by enable A.
// RQ11 - Event mode rising pin B edge sets pending B, gated by enable B.
// RQ12 - Event mode drives no PWM output on pin A.
// RQ13 - Capture mode counts freely; pin edges copy count into register A or B.
// RQ14 - Capture edge polarity chosen separately for each pin via mode bits; m1 picks pin A, pin B is falling except in code 0,1,0.
// RQ15 - Capture edge on A sets pending A, on B sets pending B.
// RQ16 - Capture underflow sets run bit as underflow flag, enabled by enable A.
// RQ17 - Software clears run bit when entering capture mode.
// RQ18 - Software checks pending A and underflow flag on interrupt A.
// RQ19 - Sixteen-bit counter, two sixteen-bit registers, one two-way pin, one input pin.
// RQ20 - Counter and reload registers are not initialised by reset.
// RQ21 - Control register: mode bits and run in 7..4, then pnda, ena, pndb, enb.
// RQ22 - Hardware set beats software clear of the same flag in one cycle.
`timescale 1ns/1ps

module tmt_timer (
  input  wire logic                     i_clk,        // 125 MHz clock
  input  wire logic                     i_rst_n,      // Synchronous reset, active low
  input  wire logic [2:0]               i_addr,       // Register address
  input  wire logic [tmt_pkg::REG_W-1:0] i_wdata,     // Write data
  input  wire logic                     i_wr,         // Write strobe
  input  wire logic                     i_rd,         // Read strobe
  output logic      [tmt_pkg::REG_W-1:0] o_rdata,     // Read data, cycle after strobe
  input  wire logic                     i_pin_a,      // Timer pin A input level
  output logic                          o_pin_a,      // Timer pin A output level
  output logic                          o_pin_a_oe,   // Timer pin A output enable
  input  wire logic                     i_pin_b,      // Timer pin B input
  output logic                          o_irq_a,      // Interrupt request A
  output logic                          o_irq_b       // Interrupt request B
);

  // ==========================================================================
  // Declarations
  tmt_pkg::tmt_bus_type                 bus;
  tmt_pkg::tmt_ctrl_type                ctrl_q;
  tmt_pkg::tmt_mode_type                mode;
  logic [tmt_pkg::CNT_W-1:0]            cnt_q;
  logic [tmt_pkg::CNT_W-1:0]            ra_q;
  logic [tmt_pkg::CNT_W-1:0]            rb_q;
  logic [tmt_pkg::REG_W-1:0]            tick_div_q;
  logic [tmt_pkg::REG_W-1:0]            tick_cnt_q;
  logic                                 tick;
  logic                                 next_b_q;     // Next reload source is B
  logic                                 pin_out_q;
  logic [1:0]                           sync_a_q;
  logic [1:0]                           sync_b_q;
  logic                                 prev_a_q;
  logic                                 prev_b_q;
  logic                                 rise_a;
  logic                                 fall_a;
  logic                                 rise_b;
  logic                                 fall_b;
  logic                                 edge_a_sel;
  logic                                 edge_b_sel;
  logic                                 dec;
  logic                                 uflow;
  logic                                 wr_ctrl;
  logic                                 set_pnda;
  logic                                 set_pndb;
  logic                                 set_run;
  logic [tmt_pkg::REG_W-1:0]            rdata_d;
  logic [1:0]                           cnt_known_q;  // Counter bytes written since reset

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // ==========================================================================
  // Mode decode
  always_comb begin
    if (ctrl_q.m3 && !ctrl_q.m2) begin
      mode = tmt_pkg::TMT_PWM;                        // [RQ8]
    end else if (!ctrl_q.m3 && !ctrl_q.m2) begin
      mode = tmt_pkg::TMT_EVENT;                      // [RQ8]
    end else begin
      mode = tmt_pkg::TMT_CAPTURE;                    // [RQ8]
    end
  end

  // ==========================================================================
  // Instruction-cycle tick divider
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || tick) begin
      tick_cnt_q <= tmt_pkg::ZERO8;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end

  assign tick = (tick_cnt_q >= tick_div_q);

  // ==========================================================================
  // Pin synchronisers and edge detect
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync_a_q <= 2'h0;
      sync_b_q <= 2'h0;
      prev_a_q <= 1'b0;
      prev_b_q <= 1'b0;
    end else begin
      sync_a_q <= {sync_a_q[0], i_pin_a};
      sync_b_q <= {sync_b_q[0], i_pin_b};
      prev_a_q <= sync_a_q[1];
      prev_b_q <= sync_b_q[1];
    end
  end

  assign rise_a = sync_a_q[1] && !prev_a_q;
  assign fall_a = !sync_a_q[1] && prev_a_q;
  assign rise_b = sync_b_q[1] && !prev_b_q;
  assign fall_b = !sync_b_q[1] && prev_b_q;

  // Edge choice: event mode code 0,0,x counts rising; capture per mode bits
  always_comb begin
    edge_a_sel = rise_a;
    edge_b_sel = rise_b;
    if (mode == tmt_pkg::TMT_CAPTURE) begin
      edge_a_sel = ctrl_q.m1 ? fall_a : rise_a;       // [RQ14]
      edge_b_sel = ctrl_q.m3 ? fall_b : rise_b;       // [RQ14]
      if (ctrl_q.m1 && !ctrl_q.m3) begin
        edge_b_sel = fall_b;                          // [RQ14]
      end
    end
  end

  // ==========================================================================
  // Count enable and underflow
  always_comb begin
    case (mode)
      tmt_pkg::TMT_PWM:     dec = ctrl_q.run && tick;         // [RQ1] [RQ7]
      tmt_pkg::TMT_EVENT:   dec = ctrl_q.run && edge_a_sel;   // [RQ9] [RQ7]
      tmt_pkg::TMT_CAPTURE: dec = tick;                       // [RQ13]
      default:              dec = 1'b0;
    endcase
  end

  assign uflow = dec && (cnt_q == tmt_pkg::CNT_ZERO);

  // ==========================================================================
  // Counter, no reset on purpose
  always_ff @(posedge i_clk) begin
    if (bus.wr && bus.addr == tmt_pkg::OFF_CNT_L) begin
      cnt_q[7:0] <= bus.wdata;
    end else if (bus.wr && bus.addr == tmt_pkg::OFF_CNT_H) begin
      cnt_q[15:8] <= bus.wdata;
    end else if (uflow && mode != tmt_pkg::TMT_CAPTURE) begin
      cnt_q <= next_b_q ? rb_q : ra_q;                        // [RQ1] [RQ2] [RQ20]
    end else if (dec) begin
      cnt_q <= cnt_q - tmt_pkg::CNT_ONE;                      // [RQ1] [RQ13]
    end
  end

  // ==========================================================================
  // Counter contents known once both bytes are written; checks only
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_known_q <= 2'h0;
    end else if (bus.wr && bus.addr == tmt_pkg::OFF_CNT_L) begin
      cnt_known_q[0] <= 1'b1;                                 // [RQ20]
    end else if (bus.wr && bus.addr == tmt_pkg::OFF_CNT_H) begin
      cnt_known_q[1] <= 1'b1;                                 // [RQ20]
    end
  end

  // Reload/capture registers, no reset
  always_ff @(posedge i_clk) begin
    if (mode == tmt_pkg::TMT_CAPTURE && edge_a_sel) begin
      ra_q <= cnt_q;                                          // [RQ13]
    end else if (bus.wr && bus.addr == tmt_pkg::OFF_RA_L) begin
      ra_q[7:0] <= bus.wdata;                                 // [RQ20]
    end else if (bus.wr && bus.addr == tmt_pkg::OFF_RA_H) begin
      ra_q[15:8] <= bus.wdata;
    end
    if (mode == tmt_pkg::TMT_CAPTURE && edge_b_sel) begin
      rb_q <= cnt_q;                                          // [RQ13]
    end else if (bus.wr && bus.addr == tmt_pkg::OFF_RB_L) begin
      rb_q[7:0] <= bus.wdata;
    end else if (bus.wr && bus.addr == tmt_pkg::OFF_RB_H) begin
      rb_q[15:8] <= bus.wdata;
    end
  end

  // ==========================================================================
  // Alternation state: cleared whenever PWM is not running
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || mode != tmt_pkg::TMT_PWM || !ctrl_q.run) begin
      next_b_q <= 1'b0;                                       // [RQ2]
    end else if (uflow) begin
      next_b_q <= !next_b_q;                                  // [RQ2]
    end
  end

  // Pin A output toggle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_out_q <= 1'b0;
    end else if (uflow && mode == tmt_pkg::TMT_PWM && ctrl_q.m1) begin
      pin_out_q <= !pin_out_q;                                // [RQ3]
    end
  end

  assign o_pin_a    = pin_out_q;
  assign o_pin_a_oe = (mode == tmt_pkg::TMT_PWM);             // [RQ12] [RQ19]

  // ==========================================================================
  // Flag set events
  always_comb begin
    set_pnda = 1'b0;
    set_pndb = 1'b0;
    set_run  = 1'b0;
    case (mode)
      tmt_pkg::TMT_PWM: begin
        set_pnda = uflow && !next_b_q;                        // [RQ4]
        set_pndb = uflow && next_b_q;                         // [RQ4]
      end
      tmt_pkg::TMT_EVENT: begin
        set_pnda = uflow;                                     // [RQ10]
        set_pndb = rise_b;                                    // [RQ11]
      end
      tmt_pkg::TMT_CAPTURE: begin
        set_pnda = edge_a_sel;                                // [RQ15]
        set_pndb = edge_b_sel;                                // [RQ15]
        set_run  = uflow;                                     // [RQ16]
      end
      default: begin
        set_pnda = 1'b0;
      end
    endcase
  end

  assign wr_ctrl = bus.wr && bus.addr == tmt_pkg::OFF_CTRL;

  // Control register; hardware set wins over software write
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= tmt_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= bus.wdata;                                  // [RQ21]
      end
      if (set_pnda) begin
        ctrl_q.pnda <= 1'b1;                                  // [RQ5] [RQ22]
      end
      if (set_pndb) begin
        ctrl_q.pndb <= 1'b1;                                  // [RQ5] [RQ22]
      end
      if (set_run) begin
        ctrl_q.run <= 1'b1;                                   // [RQ16] [RQ22]
      end
    end
  end

  // Tick divider setting
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_div_q <= tmt_pkg::TICK_RST;
    end else if (bus.wr && bus.addr == tmt_pkg::OFF_TICK) begin
      tick_div_q <= bus.wdata;
    end
  end

  // ==========================================================================
  // Interrupt requests
  assign o_irq_a = (ctrl_q.pnda && ctrl_q.ena)
                 || (mode == tmt_pkg::TMT_CAPTURE && ctrl_q.run && ctrl_q.ena);  // [RQ6] [RQ16]
  assign o_irq_b = ctrl_q.pndb && ctrl_q.enb;                                    // [RQ6]

  // ==========================================================================
  // Read path
  always_comb begin
    case (bus.addr)
      tmt_pkg::OFF_CTRL:  rdata_d = ctrl_q;
      tmt_pkg::OFF_CNT_L: rdata_d = cnt_q[7:0];
      tmt_pkg::OFF_CNT_H: rdata_d = cnt_q[15:8];
      tmt_pkg::OFF_RA_L:  rdata_d = ra_q[7:0];
      tmt_pkg::OFF_RA_H:  rdata_d = ra_q[15:8];
      tmt_pkg::OFF_RB_L:  rdata_d = rb_q[7:0];
      tmt_pkg::OFF_RB_H:  rdata_d = rb_q[15:8];
      tmt_pkg::OFF_TICK:  rdata_d = tick_div_q;
      default:            rdata_d = tmt_pkg::ZERO8;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= tmt_pkg::ZERO8;
    end else if (bus.rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= tmt_pkg::ZERO8;
    end
  end

  // ==========================================================================
  // Checks
  chk_pnda_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // [RQ22]
    set_pnda |=> ctrl_q.pnda)
    else $error("pending A lost on set");
  chk_pndb_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // [RQ5]
    (set_pndb || (ctrl_q.pndb && !wr_ctrl)) |=> ctrl_q.pndb)
    else $error("pending B dropped");
  chk_irq_b_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)     // [RQ6]
    o_irq_b == (ctrl_q.pndb && ctrl_q.enb))
    else $error("irq B gating wrong");
  chk_pwm_reload_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)   // [RQ2]
    (uflow && mode == tmt_pkg::TMT_PWM && !next_b_q && !bus.wr) |=> (cnt_q == $past(ra_q)))
    else $error("reload from A missed");
  chk_pwm_alternate: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // [RQ1]
    (uflow && mode == tmt_pkg::TMT_PWM && !wr_ctrl) |=> (next_b_q != $past(next_b_q)))
    else $error("reload source did not alternate");
  chk_toggle_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)     // [RQ3]
    (uflow && mode == tmt_pkg::TMT_PWM) |=> (pin_out_q != $past(pin_out_q)) == $past(ctrl_q.m1))
    else $error("pin toggle wrong");
  chk_run_halts: assert property (@(posedge i_clk) disable iff (!i_rst_n)      // [RQ7]
    (&cnt_known_q && mode != tmt_pkg::TMT_CAPTURE && !ctrl_q.run && !bus.wr) |=> $stable(cnt_q))
    else $error("counter moved while halted");
  chk_irq_a_masked: assert property (@(posedge i_clk) disable iff (!i_rst_n)   // [RQ6]
    !ctrl_q.ena |-> !o_irq_a)
    else $error("irq A raised while disabled");
  chk_event_pin_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)    // [RQ11]
    (mode == tmt_pkg::TMT_EVENT && rise_b) |=> ctrl_q.pndb)
    else $error("event pin B edge missed");
  chk_no_pwm_event: assert property (@(posedge i_clk) disable iff (!i_rst_n)   // [RQ12]
    mode == tmt_pkg::TMT_EVENT |-> !o_pin_a_oe)
    else $error("pin A driven in event mode");
  chk_capture_copy: assert property (@(posedge i_clk) disable iff (!i_rst_n)   // [RQ13]
    (mode == tmt_pkg::TMT_CAPTURE && edge_a_sel) |=> (ra_q == $past(cnt_q)) && ctrl_q.pnda)
    else $error("capture A wrong");
  chk_cap_uflow_run: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // [RQ16]
    (mode == tmt_pkg::TMT_CAPTURE && uflow) |=> ctrl_q.run)
    else $error("capture underflow flag missed");

endmodule : tmt_timer

// *** tb/tmt_pin_model.sv ***
// Pin-side partner that drives the two timer input pins
`timescale 1ns/1ps

module tmt_pin_model (
  input  wire logic i_clk, // System clock
  output logic      o_pa,  // Level offered on pin A
  output logic      o_pb   // Level offered on pin B
);
  // Both pins idle low
  initial begin
    o_pa = 1'b0;
    o_pb = 1'b0;
  end

  // Change just after an edge, hold six clocks so the synchroniser sees it
  task set_a(input logic v);
    @(posedge i_clk);
    o_pa <= v;
    repeat (6) @(posedge i_clk);
  endtask : set_a

  task set_b(input logic v);
    @(posedge i_clk);
    o_pb <= v;
    repeat (6) @(posedge i_clk);
  endtask : set_b
endmodule : tmt_pin_model

// *** tb/triple_mode_timer_block_test.sv ***
// Self-checking testbench of the triple mode timer
`timescale 1ns/1ps

module triple_mode_timer_block_test;
  logic        clk;
  logic        rst_n;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        pin_a_out;
  logic        pin_a_oe;
  logic        irq_a;
  logic        irq_b;
  logic        m_pa;
  logic        m_pb;
  logic        pin_a_w;
  logic [7:0]  rv;
  logic [15:0] ra;
  logic [15:0] rb;
  int          n;
  int          num_errors;
  int          n_compared;

  // Two-way pin: the timer wins while it drives
  assign pin_a_w = pin_a_oe ? pin_a_out : m_pa;

  // 125 MHz clock
  always #4 clk = ~clk;

  tmt_timer DUT (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_pin_a(pin_a_w), .o_pin_a(pin_a_out), .o_pin_a_oe(pin_a_oe),
    .i_pin_b(m_pb), .o_irq_a(irq_a), .o_irq_b(irq_b));

  tmt_pin_model PINS (.i_clk(clk), .o_pa(m_pa), .o_pb(m_pb));

  task finish_test;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // Low byte at a, high byte at the next offset
  task rd16(input logic [2:0] a, output logic [15:0] d);
    rd_reg(a, d[7:0]);
    rd_reg(a + 3'h1, d[15:8]);
  endtask : rd16

  // Bounded wait on irq A (0), irq B (1) or pin A output (2)
  task wait_for(input int sel, input logic v);
    n = 0;
    while ((sel == 0 ? irq_a : sel == 1 ? irq_b : pin_a_out) !== v && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 300) begin
      num_errors++;
      $display("[FAIL] t=%0t wait %h for %h", $time, sel, v);
      finish_test();
    end
  endtask : wait_for

  task t_reset;
    rd_reg(tmt_pkg::OFF_CTRL, rv);
    chk(16'(rv), 16'(tmt_pkg::CTRL_RST));
    rd_reg(tmt_pkg::OFF_TICK, rv);
    chk(16'(rv), 16'(tmt_pkg::TICK_RST));
    chk(16'({pin_a_oe, irq_a, irq_b}), 16'h0000);
  endtask : t_reset

  // Toggling PWM, reload A = 3, reload B = 5, tick every clock
  task t_pwm;
    wr_reg(tmt_pkg::OFF_TICK, 8'h00);
    wr_reg(tmt_pkg::OFF_RA_L, 8'h03);
    wr_reg(tmt_pkg::OFF_RA_H, 8'h00);
    wr_reg(tmt_pkg::OFF_RB_L, 8'h05);
    wr_reg(tmt_pkg::OFF_RB_H, 8'h00);
    wr_reg(tmt_pkg::OFF_CNT_L, 8'h00);
    wr_reg(tmt_pkg::OFF_CNT_H, 8'h00);
    wr_reg(tmt_pkg::OFF_CTRL, 8'hB5);
    wait_for(2, 1'b1);
    @(posedge clk);
    #1;
    chk(16'({pin_a_oe, irq_a, irq_b}), 16'h0006);
    wait_for(2, 1'b0);
    chk(16'(n), 16'h0003);
    @(posedge clk);
    #1;
    chk(16'(irq_b), 16'h0001);
    wait_for(2, 1'b1);
    chk(16'(n), 16'h0005);
  endtask : t_pwm

  // PWM without toggle, enable A off, then stop
  task t_notoggle;
    wr_reg(tmt_pkg::OFF_CTRL, 8'h91);
    @(posedge clk);
    #1;
    ra[0] = pin_a_out;
    repeat (14) @(posedge clk);
    #1;
    chk(16'(pin_a_out), 16'(ra[0]));
    chk(16'(irq_a), 16'h0000);
    rd_reg(tmt_pkg::OFF_CTRL, rv);
    chk(16'(rv), 16'h009B);
    wr_reg(tmt_pkg::OFF_CTRL, 8'h80);
    wr_reg(tmt_pkg::OFF_CTRL, 8'h80);
    rd16(tmt_pkg::OFF_CNT_L, ra);
    rd16(tmt_pkg::OFF_CNT_L, rb);
    chk(rb, ra);
    rd_reg(tmt_pkg::OFF_CTRL, rv);
    chk(16'(rv), 16'h0080);
  endtask : t_notoggle

  // Both event-counter codes: pin A edges count, pin B sets flag B
  task t_event;
    logic [7:0] c;
    for (int i = 0; i < 2; i++) begin
      c = {2'b00, i[0], 5'h15};
      wr_reg(tmt_pkg::OFF_CNT_L, 8'h01);
      wr_reg(tmt_pkg::OFF_CNT_H, 8'h00);
      wr_reg(tmt_pkg::OFF_RA_L, 8'h02);
      wr_reg(tmt_pkg::OFF_CTRL, c);
      PINS.set_a(1'b1);
      PINS.set_a(1'b0);
      rd_reg(tmt_pkg::OFF_CTRL, rv);
      chk(16'(rv), 16'(c));
      chk(16'(pin_a_oe), 16'h0000);
      PINS.set_a(1'b1);
      PINS.set_a(1'b0);
      rd_reg(tmt_pkg::OFF_CTRL, rv);
      chk(16'(rv), 16'(c | 8'h08));
      rd16(tmt_pkg::OFF_CNT_L, ra);
      chk(ra, 16'h0002);
      PINS.set_b(1'b1);
      PINS.set_b(1'b0);
      chk(16'({irq_a, irq_b}), 16'h0003);
    end
  endtask : t_event

  // Every capture code, pin B edge ten clocks after pin A edge
  task t_capture;
    logic [2:0] code;
    logic       ar;
    logic       br;
    wr_reg(tmt_pkg::OFF_CNT_L, 8'h00);
    wr_reg(tmt_pkg::OFF_CNT_H, 8'h80);
    for (int i = 0; i < 4; i++) begin
      code = {i[0], 1'b1, i[1]};
      ar = ~code[0];
      br = (code == 3'b010);
      PINS.set_a(~ar);
      PINS.set_b(~br);
      wr_reg(tmt_pkg::OFF_CTRL, {code, 5'h05});
      PINS.set_a(ar);
      repeat (3) @(posedge clk);
      PINS.set_b(br);
      rd16(tmt_pkg::OFF_RA_L, ra);
      rd16(tmt_pkg::OFF_RB_L, rb);
      chk(ra - rb, 16'h000A);
      rd_reg(tmt_pkg::OFF_CTRL, rv);
      chk(16'(rv), 16'({code, 5'h0F}));
      chk(16'({irq_a, irq_b}), 16'h0003);
    end
    // Entering with run cleared, then let the counter underflow
    wr_reg(tmt_pkg::OFF_CTRL, 8'h45);
    wr_reg(tmt_pkg::OFF_CNT_L, 8'h10);
    wr_reg(tmt_pkg::OFF_CNT_H, 8'h00);
    repeat (30) @(posedge clk);
    rd_reg(tmt_pkg::OFF_CTRL, rv);
    chk(16'({rv, 7'h00, irq_a}), 16'h5501);
    wr_reg(tmt_pkg::OFF_CTRL, 8'h41);
    @(posedge clk);
    #1;
    chk(16'(irq_a), 16'h0000);
  endtask : t_capture

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_pwm();
    t_notoggle();
    t_event();
    t_capture();
    finish_test();
  end
endmodule : triple_mode_timer_block_test
